// [hw/tsp_core.sv]
// touch state processor: apb registers, scan sequencer and per-sensor state
`timescale 1ns/1ns
`default_nettype none
`include "tsp_regs.svh"

// Behaviour
// RULE1 - difference is raw minus baseline, zero if negative or under noise threshold
// RULE2 - baseline slowly tracks raw count, weakly following sudden changes
// RULE3 - on above threshold plus hysteresis, off below threshold minus hysteresis
// RULE4 - touch declared only after debounce consecutive samples above upper bound
// RULE5 - count abnormally low samples; past the limit, baseline loads raw count
// RULE6 - every button reports only two states, touched or not touched
// RULE7 - ganged sensors scanned together give one raw count
// RULE8 - low power scans ganged; a touch there starts individual scanning
// RULE9 - a touched guard sensor suppresses scanning of all other sensors
// RULE10 - four rows by four columns resolve sixteen keys, one valid at once
// RULE11 - baseline tracks only while baseline minus raw stays below negative threshold
// RULE12 - auto reset updates baseline always, else only when difference is under noise; the code does not track a low sample (RULE11) even with auto reset
// RULE13 - front end delivers raw counts as wide as the scan resolution
// RULE14 - between hysteresis bounds the reported state is held
// RULE15 - one full update per completed scan with valid raw count
module tsp_core (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             fe_scan_start,
	output logic [8:0]       fe_scan_mask,
	input  wire logic        fe_scan_done,
	input  wire logic [15:0] fe_raw_count,
	output logic [7:0]       sensor_on,
	output logic             guard_on,
	output logic             active_mode,
	output logic             touch_valid,
	output logic [1:0]       touch_row,
	output logic [1:0]       touch_col
);

	tsp_pkg::tsp_ctrl_t    ctrl_q;
	tsp_pkg::tsp_params_t  prm;
	logic [4:0]            res_q;
	logic [15:0]           fth_q;
	logic [15:0]           hyst_q;
	logic [15:0]           nth_q;
	logic [15:0]           nnth_q;
	logic [7:0]            deb_q;
	logic [7:0]            lbr_q;
	logic [3:0]            sel_q;

	tsp_pkg::tsp_slot_t    slot_q [0:`TSP_NUM_SLOTS-1];
	logic [15:0]           diff_q [0:`TSP_NUM_SLOTS-1];
	tsp_pkg::tsp_slot_t    calc_nxt;
	logic [15:0]           calc_diff;

	tsp_pkg::tsp_scan_st_t st_q;
	tsp_pkg::tsp_scan_st_t st_d;
	logic [3:0]            cur_q;
	logic [3:0]            cur_d;
	logic                  active_q;
	logic                  active_d;
	logic                  start_q;
	logic [8:0]            mask_q;
	logic [8:0]            mask_d;
	logic                  done_ev;
	logic [3:0]            first_slot;

	logic                  wr_en;
	logic                  setup;
	logic [31:0]           rd_d;
	logic                  err_d;
	logic [31:0]           prdata_q;
	logic                  err_q;

	logic [7:0]            on_vec;
	logic [3:0]            rows;
	logic [3:0]            cols;
	logic                  tv_q;
	logic [1:0]            row_q;
	logic [1:0]            col_q;

	function automatic logic one_hot(input logic [3:0] v);
		one_hot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
	endfunction : one_hot

	function automatic logic [1:0] enc4(input logic [3:0] v);
		enc4 = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction : enc4

	// apb register access
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pwrite;
	assign pready = 1'b1;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_q <= '0;
			res_q  <= `TSP_RST_RES;
			fth_q  <= `TSP_RST_FTH;
			hyst_q <= `TSP_RST_HYST;
			nth_q  <= `TSP_RST_NTH;
			nnth_q <= `TSP_RST_NNTH;
			deb_q  <= `TSP_RST_DEB;
			lbr_q  <= `TSP_RST_LBR;
			sel_q  <= 4'h0;
		end else if (wr_en) begin
			case (paddr)
				`TSP_OFF_CTRL: begin
					ctrl_q.enable     <= pwdata[`TSP_CTRL_ENABLE];
					ctrl_q.lp_en      <= pwdata[`TSP_CTRL_LP];
					ctrl_q.guard_en   <= pwdata[`TSP_CTRL_GUARD];
					ctrl_q.auto_reset <= pwdata[`TSP_CTRL_AUTORST];
					ctrl_q.matrix_en  <= pwdata[`TSP_CTRL_MATRIX];
				end
				`TSP_OFF_RES:     res_q  <= pwdata[4:0];
				`TSP_OFF_FTH:     fth_q  <= pwdata[15:0];
				`TSP_OFF_HYST:    hyst_q <= pwdata[15:0];
				`TSP_OFF_NTH:     nth_q  <= pwdata[15:0];
				`TSP_OFF_NNTH:    nnth_q <= pwdata[15:0];
				`TSP_OFF_DEB:     deb_q  <= pwdata[7:0];
				`TSP_OFF_LBR:     lbr_q  <= pwdata[7:0];
				`TSP_OFF_SLOTSEL: sel_q  <= pwdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// read data is decoded in the setup phase and held through the access phase
	always_comb begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		case (paddr)
			`TSP_OFF_CTRL: begin
				rd_d[`TSP_CTRL_ENABLE]  = ctrl_q.enable;
				rd_d[`TSP_CTRL_LP]      = ctrl_q.lp_en;
				rd_d[`TSP_CTRL_GUARD]   = ctrl_q.guard_en;
				rd_d[`TSP_CTRL_AUTORST] = ctrl_q.auto_reset;
				rd_d[`TSP_CTRL_MATRIX]  = ctrl_q.matrix_en;
			end
			`TSP_OFF_RES:     rd_d[4:0]  = res_q;
			`TSP_OFF_FTH:     rd_d[15:0] = fth_q;
			`TSP_OFF_HYST:    rd_d[15:0] = hyst_q;
			`TSP_OFF_NTH:     rd_d[15:0] = nth_q;
			`TSP_OFF_NNTH:    rd_d[15:0] = nnth_q;
			`TSP_OFF_DEB:     rd_d[7:0]  = deb_q;
			`TSP_OFF_LBR:     rd_d[7:0]  = lbr_q;
			`TSP_OFF_STATUS: begin
				rd_d[7:0]   = on_vec;
				rd_d[8]     = slot_q[`TSP_SLOT_GUARD].on;
				rd_d[9]     = slot_q[`TSP_SLOT_GANG].on;
				rd_d[10]    = active_q;
				rd_d[11]    = tv_q;
				rd_d[13:12] = row_q;
				rd_d[15:14] = col_q;
			end
			`TSP_OFF_SLOTSEL: rd_d[3:0]  = sel_q;
			`TSP_OFF_BASE: begin
				if (sel_q < 4'(`TSP_NUM_SLOTS)) begin
					rd_d[15:0] = slot_q[sel_q].base;
				end
			end
			`TSP_OFF_DIFF: begin
				if (sel_q < 4'(`TSP_NUM_SLOTS)) begin
					rd_d[15:0] = diff_q[sel_q];
				end
			end
			default:          err_d      = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
			err_q    <= err_d;
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = psel && penable && err_q;

	// per-sensor processing
	// one driver for the whole parameter bundle handed to the slot calculator
	always_comb begin
		prm.res        = res_q;
		prm.fth        = fth_q;
		prm.hyst       = hyst_q;
		prm.nth        = nth_q;
		prm.nnth       = nnth_q;
		prm.deb        = deb_q;
		prm.lbr        = lbr_q;
		prm.auto_reset = ctrl_q.auto_reset;
	end

	tsp_slot_calc u_calc (
		.prm  (prm),
		.raw  (fe_raw_count),
		.cur  (slot_q[cur_q]),
		.nxt  (calc_nxt),
		.diff (calc_diff)
	);

	// a completed scan counts only while the sequencer waits for it
	assign done_ev = (st_q == tsp_pkg::ST_WAIT) && fe_scan_done;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < `TSP_NUM_SLOTS; i++) begin
				slot_q[i] <= '0;
				diff_q[i] <= 16'h0000;
			end
		end else if (done_ev) begin
			slot_q[cur_q] <= calc_nxt; // [RULE15]
			diff_q[cur_q] <= calc_diff;
		end
	end

	// scan sequencer
	assign first_slot = ctrl_q.guard_en ? `TSP_SLOT_GUARD : 4'h0;

	always_comb begin
		st_d     = st_q;
		cur_d    = cur_q;
		active_d = active_q;
		case (st_q)
			tsp_pkg::ST_IDLE: begin
				if (ctrl_q.enable) begin
					st_d     = tsp_pkg::ST_REQ;
					active_d = !ctrl_q.lp_en;
					cur_d    = ctrl_q.lp_en ? `TSP_SLOT_GANG : first_slot; // [RULE8]
				end
			end
			tsp_pkg::ST_REQ: begin
				st_d = tsp_pkg::ST_WAIT;
			end
			tsp_pkg::ST_WAIT: begin
				if (fe_scan_done) begin
					st_d = ctrl_q.enable ? tsp_pkg::ST_REQ : tsp_pkg::ST_IDLE;
					if (cur_q == `TSP_SLOT_GANG) begin
						if (ctrl_q.enable && (calc_nxt.on || !ctrl_q.lp_en)) begin
							active_d = 1'b1; // [RULE8]
							cur_d    = first_slot;
						end
					end else if (cur_q == `TSP_SLOT_GUARD) begin
						// a wet panel keeps only the guard in the scan loop
						cur_d = calc_nxt.on ? `TSP_SLOT_GUARD : 4'h0; // [RULE9]
					end else if (cur_q == `TSP_SLOT_LAST) begin
						// the last slot's fresh result is not yet in on_vec
						if (ctrl_q.lp_en && on_vec[6:0] == 7'h00 && !calc_nxt.on) begin
							active_d = 1'b0; // [RULE8]
							cur_d    = `TSP_SLOT_GANG;
						end else begin
							cur_d = first_slot;
						end
					end else begin
						cur_d = cur_q + 4'h1;
					end
				end
			end
			default: begin
				st_d = tsp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_q     <= tsp_pkg::ST_IDLE;
			cur_q    <= 4'h0;
			active_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			cur_q    <= cur_d;
			active_q <= active_d;
		end
	end

	// ganged slot connects all buttons at once for one raw count
	always_comb begin
		if (cur_d == `TSP_SLOT_GANG) begin
			mask_d = `TSP_MASK_GANG; // [RULE7]
		end else begin
			mask_d = 9'h001 << cur_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			start_q <= 1'b0;
			mask_q  <= 9'h000;
		end else begin
			start_q <= (st_d == tsp_pkg::ST_REQ);
			if (st_d == tsp_pkg::ST_REQ) begin
				mask_q <= mask_d;
			end
		end
	end

	assign fe_scan_start = start_q;
	assign fe_scan_mask  = mask_q;

	// sensor state outputs
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			on_vec[i] = slot_q[i].on; // [RULE6]
		end
	end

	assign rows = on_vec[3:0];
	assign cols = on_vec[7:4];

	// one row and one column touched makes one valid key, anything else none
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tv_q  <= 1'b0;
			row_q <= 2'h0;
			col_q <= 2'h0;
		end else begin
			tv_q  <= ctrl_q.matrix_en && one_hot(rows) && one_hot(cols); // [RULE10]
			row_q <= enc4(rows);
			col_q <= enc4(cols);
		end
	end

	assign sensor_on   = on_vec;
	assign guard_on    = slot_q[`TSP_SLOT_GUARD].on;
	assign active_mode = active_q;
	assign touch_valid = tv_q;
	assign touch_row   = row_q;
	assign touch_col   = col_q;

endmodule : tsp_core
`default_nettype wire

// [hw/tsp_regs.svh]
// register offsets, field positions, reset values and counts of the touch state processor
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH

`define TSP_OFF_CTRL     8'h00
`define TSP_OFF_RES      8'h04
`define TSP_OFF_FTH      8'h08
`define TSP_OFF_HYST     8'h0c
`define TSP_OFF_NTH      8'h10
`define TSP_OFF_NNTH     8'h14
`define TSP_OFF_DEB      8'h18
`define TSP_OFF_LBR      8'h1c
`define TSP_OFF_STATUS   8'h20
`define TSP_OFF_SLOTSEL  8'h24
`define TSP_OFF_BASE     8'h28
`define TSP_OFF_DIFF     8'h2c

`define TSP_CTRL_ENABLE  0
`define TSP_CTRL_LP      1
`define TSP_CTRL_GUARD   2
`define TSP_CTRL_AUTORST 3
`define TSP_CTRL_MATRIX  4

`define TSP_RST_RES      5'h10
`define TSP_RST_FTH      16'h0064
`define TSP_RST_HYST     16'h000a
`define TSP_RST_NTH      16'h0028
`define TSP_RST_NNTH     16'h0028
`define TSP_RST_DEB      8'h03
`define TSP_RST_LBR      8'h32

`define TSP_NUM_SLOTS    10
`define TSP_SLOT_GUARD   4'h8
`define TSP_SLOT_GANG    4'h9
`define TSP_SLOT_LAST    4'h7
`define TSP_MASK_GANG    9'h0ff
`define TSP_BL_SHIFT     3

`endif

// [hw/tsp_pkg.sv]
// types shared by the touch state processor files
`default_nettype none
package tsp_pkg;

	typedef struct packed {
		logic matrix_en;
		logic auto_reset;
		logic guard_en;
		logic lp_en;
		logic enable;
	} tsp_ctrl_t;

	typedef struct packed {
		logic [4:0]  res;
		logic [15:0] fth;
		logic [15:0] hyst;
		logic [15:0] nth;
		logic [15:0] nnth;
		logic [7:0]  deb;
		logic [7:0]  lbr;
		logic        auto_reset;
	} tsp_params_t;

	typedef struct packed {
		logic [15:0] base;
		logic [7:0]  deb_cnt;
		logic [7:0]  low_cnt;
		logic        on;
		logic        init;
	} tsp_slot_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_WAIT
	} tsp_scan_st_t;

endpackage : tsp_pkg
`default_nettype wire

// [hw/tsp_slot_calc.sv]
// per-scan baseline, difference, debounce and state update of one sensor slot
`timescale 1ns/1ns
`default_nettype none
`include "tsp_regs.svh"

module tsp_slot_calc (
	input  wire tsp_pkg::tsp_params_t prm,
	input  wire logic [15:0]          raw,
	input  wire tsp_pkg::tsp_slot_t   cur,
	output tsp_pkg::tsp_slot_t        nxt,
	output logic [15:0]               diff
);

	logic [15:0] mask;
	logic [15:0] raw_m;
	logic [16:0] up;
	logic [16:0] dn;
	logic        pos;
	logic        low;
	logic [16:0] on_thr;
	logic [15:0] off_thr;
	logic [7:0]  deb_need;
	logic [16:0] step;

	// raw counts only carry as many bits as the scan resolution
	assign mask     = ~(16'hffff << prm.res);
	assign raw_m    = raw & mask;
	assign up       = {1'b0, raw_m} - {1'b0, cur.base};
	assign dn       = {1'b0, cur.base} - {1'b0, raw_m};
	assign pos      = ~up[16];
	assign diff     = (pos && up[15:0] >= prm.nth) ? up[15:0] : 16'h0000; // [RULE1]
	assign low      = ~pos && (dn[15:0] >= prm.nnth); // [RULE11]
	assign on_thr   = {1'b0, prm.fth} + {1'b0, prm.hyst};
	assign off_thr  = (prm.fth > prm.hyst) ? prm.fth - prm.hyst : 16'h0000;
	assign deb_need = (prm.deb == 8'h00) ? 8'h01 : prm.deb;

	// slow first-order tracking, at least one count per sample toward raw
	always_comb begin
		step = $signed(up) >>> `TSP_BL_SHIFT; // [RULE2]
		if (step == 17'h00000 && up != 17'h00000) begin
			step = pos ? 17'h00001 : 17'h1ffff;
		end
	end

	always_comb begin
		nxt      = cur;
		nxt.init = 1'b1;
		if (!cur.init) begin
			nxt.base    = raw_m;
			nxt.deb_cnt = 8'h00;
			nxt.low_cnt = 8'h00;
			nxt.on      = 1'b0;
		end else begin
			if (low) begin
				if (cur.low_cnt >= prm.lbr) begin
					nxt.base    = raw_m; // [RULE5]
					nxt.low_cnt = 8'h00;
				end else begin
					nxt.low_cnt = cur.low_cnt + 8'h01; // [RULE5]
				end
			end else begin
				nxt.low_cnt = 8'h00;
				if (prm.auto_reset || !pos || up[15:0] < prm.nth) begin
					nxt.base = cur.base + step[15:0]; // [RULE12]
				end
			end
			if ({1'b0, diff} > on_thr) begin
				if ({1'b0, cur.deb_cnt} + 9'h001 >= {1'b0, deb_need}) begin
					nxt.on = 1'b1; // [RULE3] [RULE4]
				end else begin
					nxt.deb_cnt = cur.deb_cnt + 8'h01; // [RULE4]
				end
			end else begin
				nxt.deb_cnt = 8'h00;
				if (diff < off_thr) begin
					nxt.on = 1'b0; // [RULE3]
				end
				// otherwise the reported state is kept [RULE14]
			end
		end
	end

endmodule : tsp_slot_calc
`default_nettype wire

// [tb/tsp_core_monitor.sv]
// checker of scan sequencing, sensor state and bus decode at the core ports
`timescale 1ns/1ns
`default_nettype none
module tsp_core_monitor (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pslverr,
	input wire logic       fe_scan_start,
	input wire logic [8:0] fe_scan_mask,
	input wire logic       fe_scan_done,
	input wire logic [7:0] sensor_on,
	input wire logic       guard_on,
	input wire logic       active_mode,
	input wire logic       touch_valid,
	input wire logic [1:0] touch_row,
	input wire logic [1:0] touch_col
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	start_pulse_a: assert property (fe_scan_start |=> !fe_scan_start)
		else $error("scan start held longer than one cycle");
	mask_hold_a: assert property (!fe_scan_start |-> $stable(fe_scan_mask))
		else $error("scan mask moved without a scan start");
	state_src_a: assert property (
		!$stable(sensor_on) |-> ($past(fe_scan_done) || $past(fe_scan_done, 2))
		&& ((sensor_on ^ $past(sensor_on)) & ~$past(fe_scan_mask[7:0])) == 8'h00)
		else $error("button state changed without a scan of that button");
	guard_src_a: assert property ($rose(guard_on) |-> $past(fe_scan_mask) == 9'h100)
		else $error("guard state rose without a guard scan");
	guard_only_a: assert property (guard_on && fe_scan_start |-> fe_scan_mask == 9'h100)
		else $error("button scanned while guard touched");
	gang_wake_a: assert property (
		$rose(active_mode) |-> fe_scan_start && fe_scan_mask != 9'h0ff)
		else $error("active mode entered without an individual scan");
	gang_back_a: assert property ($fell(active_mode) |-> sensor_on == 8'h00)
		else $error("left active mode with a button on");
	key_valid_a: assert property (
		$rose(touch_valid) |-> sensor_on[touch_row] && sensor_on[{1'b1, touch_col}])
		else $error("matrix key valid without its row and column on");
	bus_err_a: assert property (psel && penable && paddr > 8'h2c |-> pslverr)
		else $error("unmapped access without slave error");
	bus_ok_a: assert property (psel && penable && paddr[1:0] == 2'b00
		&& paddr <= 8'h2c |-> !pslverr)
		else $error("slave error on a mapped register");
endmodule : tsp_core_monitor

bind tsp_core tsp_core_monitor tsp_core_monitor_i (.core_clk, .rst_b, .psel, .penable, .paddr,
	.pslverr, .fe_scan_start, .fe_scan_mask, .fe_scan_done, .sensor_on, .guard_on,
	.active_mode, .touch_valid, .touch_row, .touch_col);
`default_nettype wire

// [tb/tsp_fe_model.sv]
// behavioural sensing front end answering each scan request with one raw count
`timescale 1ns/1ns
`default_nettype none
module tsp_fe_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       fe_scan_start,
	input  wire logic [8:0] fe_scan_mask,
	output logic            fe_scan_done,
	output logic [15:0]     fe_raw_count
);
	logic [15:0] lvl [10];
	logic [3:0]  pick;
	logic [3:0]  slot_q;
	int          wait_q;

	initial begin
		fe_scan_done = 1'b0;
		fe_raw_count = 16'h0000;
		wait_q = 0;
		slot_q = 4'h0;
	end

	// all buttons selected is the ganged sensor
	always_comb begin
		pick = 4'h9;
		if (fe_scan_mask[8])
			pick = 4'h8;
		for (int i = 0; i < 8; i++)
			if (fe_scan_mask == 9'(1 << i))
				pick = 4'(i);
	end

	always @(posedge core_clk) begin
		fe_scan_done <= 1'b0;
		fe_raw_count <= ~fe_raw_count; // count lines not held outside a result
		if (!rst_b) begin
			wait_q <= 0;
		end else if (fe_scan_start) begin
			wait_q <= 1 + $urandom_range(7);
			slot_q <= pick;
		end else if (wait_q == 1) begin
			fe_scan_done <= 1'b1;
			fe_raw_count <= lvl[slot_q];
			wait_q <= 0;
		end else if (wait_q > 1) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule : tsp_fe_model
`default_nettype wire

// [tb/tb.sv]
// testbench of the touch state processor with its front end model
`timescale 1ns/1ns
`default_nettype none
`include "tsp_regs.svh"
module tb;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, fe_scan_start, fe_scan_done;
	logic [8:0]  fe_scan_mask;
	logic [15:0] fe_raw_count;
	logic [7:0]  sensor_on;
	logic        guard_on, active_mode, touch_valid;
	logic [1:0]  touch_row, touch_col;
	int          errors = 0;
	int          samples_checked = 0;
	int          scans [10];
	int          s, r, c, n0;
	localparam int LV [6] = '{1150, 1150, 1150, 1095, 1089, 1030};
	localparam bit ON [6] = '{0, 0, 1, 1, 0, 0};

	always #4 core_clk = ~core_clk;

	tsp_core tsp_core_i (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .fe_scan_start, .fe_scan_mask, .fe_scan_done,
		.fe_raw_count, .sensor_on, .guard_on, .active_mode, .touch_valid, .touch_row,
		.touch_col);
	tsp_fe_model tsp_fe_model_i (.core_clk, .rst_b, .fe_scan_start, .fe_scan_mask,
		.fe_scan_done, .fe_raw_count);

	always @(posedge core_clk)
		if (fe_scan_done)
			scans[tsp_fe_model_i.slot_q] <= scans[tsp_fe_model_i.slot_q] + 1;

	function automatic logic [15:0] exp_base(input logic [15:0] b, input logic [15:0] rw);
		logic signed [16:0] d;
		logic signed [16:0] st;
		d = {1'b0, rw} - {1'b0, b};
		st = d >>> 3;
		if (st == 0 && d != 0)
			st = d > 0 ? 17'sd1 : -17'sd1;
		return b + st[15:0];
	endfunction : exp_base

	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string w);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(w, x, q);
		chk("pslverr", 32'(a > 8'h2c), 32'(e));
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic go(input logic [31:0] ctl);
		rst_b <= 1'b0;
		for (int i = 0; i < 10; i++)
			tsp_fe_model_i.lvl[i] <= 16'd1000;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		wr(`TSP_OFF_SLOTSEL, 32'(s));
		wr(`TSP_OFF_CTRL, ctl);
	endtask : go

	// waits for n more completed scans of slot k; only the watchdog ends a hang
	task automatic await(input int k, input int n);
		int t;
		t = scans[k] + n;
		while (scans[k] < t)
			@(posedge core_clk);
		repeat (2) @(posedge core_clk);
	endtask : await

	task automatic test_end(input string n);
		$display("test %s finished, mismatches %0d", n, errors);
	endtask : test_end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		conclude();
	end

	initial begin
		void'($urandom(22));
		s = $urandom_range(7);
		r = $urandom_range(3);
		c = $urandom_range(3);
		go(32'h0);
		rd(`TSP_OFF_CTRL, 32'h0, "ctrl");
		rd(`TSP_OFF_RES, 32'(`TSP_RST_RES), "res");
		rd(`TSP_OFF_FTH, 32'(`TSP_RST_FTH), "fth");
		rd(`TSP_OFF_HYST, 32'(`TSP_RST_HYST), "hyst");
		rd(`TSP_OFF_NTH, 32'(`TSP_RST_NTH), "nth");
		rd(`TSP_OFF_NNTH, 32'(`TSP_RST_NNTH), "nnth");
		rd(`TSP_OFF_DEB, 32'(`TSP_RST_DEB), "deb");
		rd(`TSP_OFF_LBR, 32'(`TSP_RST_LBR), "lbr");
		rd(8'h30, 32'h0, "unmapped");
		n0 = $urandom_range(16'hffff);
		wr(`TSP_OFF_FTH, 32'(n0));
		rd(`TSP_OFF_FTH, 32'(n0), "fth");
		test_end("registers");

		go(32'h1);
		await(s, 1);
		for (int i = 0; i < 6; i++) begin
			tsp_fe_model_i.lvl[s] <= 16'(LV[i]);
			await(s, 1);
			chk("sensor_on", 32'(ON[i]), 32'(sensor_on[s]));
		end
		rd(`TSP_OFF_BASE, 32'(exp_base(16'd1000, 16'd1030)), "base");
		rd(`TSP_OFF_DIFF, 32'h0, "diff");
		test_end("threshold");

		go(32'h0);
		wr(`TSP_OFF_LBR, 32'h2);
		wr(`TSP_OFF_CTRL, 32'h1);
		await(s, 1);
		tsp_fe_model_i.lvl[s] <= 16'd900;
		await(s, 2);
		rd(`TSP_OFF_BASE, 32'd1000, "base");
		await(s, 1);
		rd(`TSP_OFF_BASE, 32'd900, "base");
		test_end("low baseline");

		go(32'h9);
		await(s, 1);
		tsp_fe_model_i.lvl[s] <= 16'd1150;
		await(s, 2);
		rd(`TSP_OFF_BASE, 32'(exp_base(exp_base(16'd1000, 16'd1150), 16'd1150)), "base");
		test_end("auto reset");

		go(32'h3);
		await(9, 1);
		chk("active", 32'h0, 32'(active_mode));
		tsp_fe_model_i.lvl[9] <= 16'd1150;
		await(9, 3);
		for (int i = 0; i < 50 && active_mode !== 1'b1; i++)
			@(posedge core_clk);
		chk("active", 32'h1, 32'(active_mode));
		tsp_fe_model_i.lvl[9] <= 16'd1000;
		for (int i = 0; i < 800 && active_mode !== 1'b0; i++)
			@(posedge core_clk);
		chk("active", 32'h0, 32'(active_mode));
		test_end("low power");

		go(32'h5);
		await(8, 1);
		tsp_fe_model_i.lvl[8] <= 16'd1150;
		await(8, 3);
		chk("guard", 32'h1, 32'(guard_on));
		n0 = scans[s];
		repeat (200) @(posedge core_clk);
		chk("suppressed", 32'(n0), 32'(scans[s]));
		test_end("guard");

		go(32'h11);
		await(7, 1);
		tsp_fe_model_i.lvl[r] <= 16'd1150;
		tsp_fe_model_i.lvl[4 + c] <= 16'd1150;
		await(7, 3);
		chk("touch", 32'h1, 32'(touch_valid));
		chk("row", 32'(r), 32'(touch_row));
		chk("col", 32'(c), 32'(touch_col));
		n0 = 32'h0c00 | (r << 12) | (c << 14) | (1 << r) | (1 << (4 + c));
		rd(`TSP_OFF_STATUS, 32'(n0), "status");
		test_end("matrix");
		conclude();
	end
endmodule : tb
`default_nettype wire
